// >>> core/adc_ctrl_pkg.sv
package adc_ctrl_pkg;

  // register byte offsets on the bus (control pair, result pair, irq pair, pin select)
  localparam logic [7:0] CTRL_FIRST_OFS  = 8'h00;
  localparam logic [7:0] CTRL_SECOND_OFS = 8'h04;
  localparam logic [7:0] RESULT_HIGH_OFS = 8'h08;
  localparam logic [7:0] RESULT_LOW_OFS  = 8'h0C;
  localparam logic [7:0] IRQ_STATUS_OFS  = 8'h10;
  localparam logic [7:0] IRQ_MASK_OFS    = 8'h14;
  localparam logic [7:0] PIN_SELECT_OFS  = 8'h18;

  // converter_control_first field positions
  localparam int START_BIT  = 7;
  localparam int BUSY_BIT   = 6;
  localparam int POWER_BIT  = 5;
  localparam int ALIGN_BIT  = 4;
  localparam int CHAN_LSB   = 0;
  // converter_control_second field positions
  localparam int SRC_LSB    = 4;
  localparam int DIV_LSB    = 0;

  // reset values
  localparam logic [7:0] CTRL_FIRST_RST  = 8'h00;
  localparam logic [7:0] CTRL_SECOND_RST = 8'h00;
  localparam logic [8:0] PIN_SELECT_RST  = 9'h000;

  // timing: 4 sampling periods then 12 converting periods
  localparam int SAMPLE_PERIODS  = 4;
  localparam int CONVERT_PERIODS = 12;
  localparam int TOTAL_PERIODS   = SAMPLE_PERIODS + CONVERT_PERIODS;

  // axi response codes
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // analog route chosen for the converter input
  typedef enum logic [2:0] {
    ROUTE_PIN,
    ROUTE_FLOAT,
    ROUTE_SUPPLY,
    ROUTE_REFERENCE,
    ROUTE_GROUND
  } route_t;

  typedef enum logic [1:0] {
    CONV_IDLE,
    CONV_SAMPLE,
    CONV_CONVERT
  } conv_state_t;

  // analog mux control carried together
  typedef struct packed {
    route_t     route;
    logic [8:0] pin_enable;  // one-hot external channel switch, zero when internal
    logic [1:0] scale;       // 0 full, 1 half, 2 quarter
  } mux_ctrl_t;

endpackage

// >>> core/adc_conversion_control.sv
// Added by the designer: the AXI4-Lite register port and the placing of the registers.
`timescale 1ns/1ps
// Contract
// - source 0000, 0100, 11xx selects external pin
// - channel codes map pins; others float
// - internal supply or reference with scaling
// - source 10xx connects ground
// - internal source opens every external switch
// - start low-high-low pulse launches conversion
// - busy flag high during conversion
// - completion sets flag; interrupt when enabled
// - three-bit divider, one to 128
// - runs only powered; software waits settling
// - 4 sample plus 12 convert periods
// - conversion never stalls the processor
// - analog pin drops pull-up and function
// - alignment bit selects result layout
// - power off keeps result registers
module adc_conversion_control
  import adc_ctrl_pkg::*;
#(
  parameter int DATA_BITS = 12,
  parameter int PIN_COUNT = 9
)(
  // clock and reset
  input  wire logic                 clk,
  input  wire logic                 rstn,
  // axi4-lite write address, data and response
  input  wire logic [7:0]           s_axi_awaddr,
  input  wire logic                 s_axi_awvalid,
  output logic                      s_axi_awready,
  input  wire logic [31:0]          s_axi_wdata,
  input  wire logic [3:0]           s_axi_wstrb,
  input  wire logic                 s_axi_wvalid,
  output logic                      s_axi_wready,
  output logic [1:0]                s_axi_bresp,
  output logic                      s_axi_bvalid,
  input  wire logic                 s_axi_bready,
  // axi4-lite read
  input  wire logic [7:0]           s_axi_araddr,
  input  wire logic                 s_axi_arvalid,
  output logic                      s_axi_arready,
  output logic [31:0]               s_axi_rdata,
  output logic [1:0]                s_axi_rresp,
  output logic                      s_axi_rvalid,
  input  wire logic                 s_axi_rready,
  // analog core
  output logic                      converter_power_enable,
  output logic                      sample_hold,
  output logic                      conv_clock_enable,
  input  wire logic [DATA_BITS-1:0] conv_result,
  output mux_ctrl_t                 mux_ctrl,
  // pin function override
  output logic [PIN_COUNT-1:0]      pin_analog_mode,
  output logic [PIN_COUNT-1:0]      pin_pullup_kill,
  // interrupt
  output logic                      irq
);

  if (DATA_BITS != 12 || PIN_COUNT != 9)
  begin : g_bad_params
    $error("adc_conversion_control supports 12 data bits and 9 pins only");
  end
  // decode the source and channel fields into an analog route
  function automatic mux_ctrl_t decode_mux(input logic [3:0] src, input logic [3:0] ch);
    mux_ctrl_t m;
    m.route      = ROUTE_PIN;
    m.pin_enable = 9'h000;
    m.scale      = 2'h0;
    if (src == 4'h0 || src == 4'h4 || src[3:2] == 2'b11)
    begin
      if (ch <= 4'h8 && ch != 4'h2)
        m.pin_enable = 9'(9'h001 << ch);
      else
        m.route = ROUTE_FLOAT;
    end
    else if (src[3:2] == 2'b10)
      m.route = ROUTE_GROUND;
    else
    begin
      // internal source: pin_enable stays zero
      m.route = src[2] ? ROUTE_REFERENCE : ROUTE_SUPPLY;
      m.scale = 2'(src[1:0] - 2'h1);
    end
    return m;
  endfunction
  logic [7:0]       ctrl_first_reg, ctrl_first_next;
  logic [7:0]       ctrl_second_reg, ctrl_second_next;
  logic [8:0]       pin_select_reg, pin_select_next;
  logic [11:0]      data_reg, data_next;
  logic             irq_status_reg, irq_status_next;
  logic             irq_mask_reg, irq_mask_next;
  logic             start_armed_reg, start_armed_next;
  logic             aw_held_reg, aw_held_next;
  logic             w_held_reg, w_held_next;
  logic [7:0]       awaddr_reg, awaddr_next;
  logic [31:0]      wdata_reg, wdata_next;
  logic             bvalid_reg, bvalid_next;
  logic [1:0]       bresp_reg, bresp_next;
  logic             rvalid_reg, rvalid_next;
  logic [31:0]      rdata_reg, rdata_next;
  logic [1:0]       rresp_reg, rresp_next;
  conv_state_t      state_reg, state_next;
  logic [3:0]       period_reg, period_next;
  logic [6:0]       div_cnt_reg, div_cnt_next;
  logic             tick, launch, done;
  logic [7:0]       result_high, result_low;
  // conversion clock enable: one pulse every 2^code system cycles
  always_comb
  begin
    logic [6:0] limit;
    limit        = 7'((8'h01 << ctrl_second_reg[DIV_LSB +: 3]) - 8'h01);
    tick         = (div_cnt_reg == limit);
    div_cnt_next = (tick || state_reg == CONV_IDLE) ? 7'h00 : 7'(div_cnt_reg + 7'h01);
  end
  // sample and convert sequencer, runs alongside the cpu
  always_comb
  begin
    state_next  = state_reg;
    period_next = period_reg;
    done        = 1'b0;
    case (state_reg)
      CONV_IDLE:
        if (launch)
        begin
          state_next  = CONV_SAMPLE;
          period_next = 4'h0;
        end
      CONV_SAMPLE, CONV_CONVERT:
        if (tick)
        begin
          period_next = 4'(period_reg + 4'h1);
          if (period_reg == 4'(SAMPLE_PERIODS - 1))
            state_next = CONV_CONVERT;
          if (period_reg == 4'(TOTAL_PERIODS - 1))
          begin
            state_next = CONV_IDLE;
            done       = ctrl_first_reg[POWER_BIT]; // no capture once powered off
          end
        end
      default:
        state_next = CONV_IDLE;
    endcase
    if (!ctrl_first_reg[POWER_BIT])
      state_next = CONV_IDLE;
  end
  // start pulse detect: arm on high, launch on the following low
  always_comb
  begin
    start_armed_next = ctrl_first_next[START_BIT];
    launch           = start_armed_reg && !start_armed_next && ctrl_first_reg[POWER_BIT];
  end
  // result capture on the completing cycle; power-off keeps it
  assign data_next = done ? conv_result : data_reg;
  // result layout per alignment bit
  assign result_high = ctrl_first_reg[ALIGN_BIT] ? {4'h0, data_reg[11:8]} : data_reg[11:4];
  assign result_low  = ctrl_first_reg[ALIGN_BIT] ? data_reg[7:0] : {4'h0, data_reg[3:0]};
  // axi write channel; address and data may arrive in either order
  always_comb
  begin
    logic wr_fire;
    wr_fire          = aw_held_reg && w_held_reg && !bvalid_reg;
    aw_held_next     = aw_held_reg;
    w_held_next      = w_held_reg;
    awaddr_next      = awaddr_reg;
    wdata_next       = wdata_reg;
    bvalid_next      = bvalid_reg;
    bresp_next       = bresp_reg;
    ctrl_first_next  = ctrl_first_reg;
    ctrl_second_next = ctrl_second_reg;
    pin_select_next  = pin_select_reg;
    irq_mask_next    = irq_mask_reg;
    irq_status_next  = irq_status_reg;
    if (s_axi_awvalid && s_axi_awready)
    begin
      aw_held_next = 1'b1;
      awaddr_next  = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready)
    begin
      w_held_next = 1'b1;
      // only byte lane 0 and 1 carry register bits; lane 1 zeroed when its strobe is low, lane 0 strobe ignored
      wdata_next  = {16'h0000, s_axi_wstrb[1] ? s_axi_wdata[15:8] : 8'h00,
                     s_axi_wdata[7:0]};
    end
    if (bvalid_reg && s_axi_bready)
      bvalid_next = 1'b0;
    if (wr_fire)
    begin
      aw_held_next = 1'b0;
      w_held_next  = 1'b0;
      bvalid_next  = 1'b1;
      bresp_next   = RESP_OKAY;
      case (awaddr_reg)
        CTRL_FIRST_OFS:  ctrl_first_next  = {wdata_reg[7], ctrl_first_reg[BUSY_BIT],
                                             wdata_reg[5:0]};
        CTRL_SECOND_OFS: ctrl_second_next = {wdata_reg[7:4], 1'b0, wdata_reg[2:0]};
        IRQ_STATUS_OFS:  irq_status_next  = irq_status_reg & ~wdata_reg[0];
        IRQ_MASK_OFS:    irq_mask_next    = wdata_reg[0];
        PIN_SELECT_OFS:  pin_select_next  = wdata_reg[8:0];
        RESULT_HIGH_OFS, RESULT_LOW_OFS: ;
        default:         bresp_next = RESP_SLVERR;
      endcase
    end
    // busy flag follows the sequencer
    ctrl_first_next[BUSY_BIT] = (state_next != CONV_IDLE);
    // completion set wins over a same-cycle clear
    if (done)
      irq_status_next = 1'b1;
  end
  // axi read channel
  always_comb
  begin
    rvalid_next = rvalid_reg;
    rdata_next  = rdata_reg;
    rresp_next  = rresp_reg;
    if (rvalid_reg && s_axi_rready)
      rvalid_next = 1'b0;
    if (s_axi_arvalid && s_axi_arready)
    begin
      rvalid_next = 1'b1;
      rresp_next  = RESP_OKAY;
      case (s_axi_araddr)
        CTRL_FIRST_OFS:  rdata_next = {24'h000000, ctrl_first_reg};
        CTRL_SECOND_OFS: rdata_next = {24'h000000, ctrl_second_reg};
        RESULT_HIGH_OFS: rdata_next = {24'h000000, result_high};
        RESULT_LOW_OFS:  rdata_next = {24'h000000, result_low};
        IRQ_STATUS_OFS:  rdata_next = {31'h00000000, irq_status_reg};
        IRQ_MASK_OFS:    rdata_next = {31'h00000000, irq_mask_reg};
        PIN_SELECT_OFS:  rdata_next = {23'h000000, pin_select_reg};
        default:
        begin
          rdata_next = 32'h00000000;
          rresp_next = RESP_SLVERR;
        end
      endcase
    end
  end
  // register every group of state
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      ctrl_first_reg  <= CTRL_FIRST_RST;
      ctrl_second_reg <= CTRL_SECOND_RST;
      pin_select_reg  <= PIN_SELECT_RST;
      data_reg        <= 12'h000;
      irq_status_reg  <= 1'b0;
      irq_mask_reg    <= 1'b0;
      start_armed_reg <= 1'b0;
      aw_held_reg     <= 1'b0;
      w_held_reg      <= 1'b0;
      awaddr_reg      <= 8'h00;
      wdata_reg       <= 32'h00000000;
      bvalid_reg      <= 1'b0;
      bresp_reg       <= RESP_OKAY;
      rvalid_reg      <= 1'b0;
      rdata_reg       <= 32'h00000000;
      rresp_reg       <= RESP_OKAY;
      state_reg       <= CONV_IDLE;
      period_reg      <= 4'h0;
      div_cnt_reg     <= 7'h00;
    end
    else
    begin
      ctrl_first_reg  <= ctrl_first_next;
      ctrl_second_reg <= ctrl_second_next;
      pin_select_reg  <= pin_select_next;
      data_reg        <= data_next;
      irq_status_reg  <= irq_status_next;
      irq_mask_reg    <= irq_mask_next;
      start_armed_reg <= start_armed_next;
      aw_held_reg     <= aw_held_next;
      w_held_reg      <= w_held_next;
      awaddr_reg      <= awaddr_next;
      wdata_reg       <= wdata_next;
      bvalid_reg      <= bvalid_next;
      bresp_reg       <= bresp_next;
      rvalid_reg      <= rvalid_next;
      rdata_reg       <= rdata_next;
      rresp_reg       <= rresp_next;
      state_reg       <= state_next;
      period_reg      <= period_next;
      div_cnt_reg     <= div_cnt_next;
    end
  end
  // handshake outputs; one held beat per channel keeps a single write in flight
  assign s_axi_awready = !aw_held_reg && !bvalid_reg;
  assign s_axi_wready  = !w_held_reg && !bvalid_reg;
  assign s_axi_arready = !rvalid_reg;
  assign s_axi_bvalid  = bvalid_reg;
  assign s_axi_bresp   = bresp_reg;
  assign s_axi_rvalid  = rvalid_reg;
  assign s_axi_rdata   = rdata_reg;
  assign s_axi_rresp   = rresp_reg;
  // analog side
  assign converter_power_enable = ctrl_first_reg[POWER_BIT];
  assign sample_hold            = (state_reg == CONV_SAMPLE);
  assign conv_clock_enable      = tick && (state_reg != CONV_IDLE);
  assign mux_ctrl = decode_mux(ctrl_second_reg[SRC_LSB +: 4], ctrl_first_reg[CHAN_LSB +: 4]);
  // analog pins lose their pull-up and digital function
  assign pin_analog_mode = pin_select_reg;
  assign pin_pullup_kill = pin_select_reg;
  assign irq             = irq_status_reg && irq_mask_reg;
  a_busy_result: assert property (@(posedge clk) disable iff (!rstn)
    $fell(ctrl_first_reg[BUSY_BIT]) && ctrl_first_reg[POWER_BIT] |->
      data_reg == $past(conv_result) && irq_status_reg)
    else $error("busy cleared without result and flag");
  a_launch_busy: assert property (@(posedge clk) disable iff (!rstn)
    launch |=> ctrl_first_reg[BUSY_BIT])
    else $error("launch did not raise busy");
  a_ground_route: assert property (@(posedge clk) disable iff (!rstn)
    ctrl_second_reg[7:6] == 2'b10 |-> mux_ctrl.route == ROUTE_GROUND)
    else $error("10xx source not grounded");
  a_internal_open: assert property (@(posedge clk) disable iff (!rstn)
    mux_ctrl.route inside {ROUTE_SUPPLY, ROUTE_REFERENCE, ROUTE_GROUND}
      |-> mux_ctrl.pin_enable == 9'h000)
    else $error("external switch closed on internal source");
  a_irq_gate: assert property (@(posedge clk) disable iff (!rstn)
    done && irq_mask_next |=> irq)
    else $error("enabled completion raised no irq");
  a_power_keep: assert property (@(posedge clk) disable iff (!rstn)
    !ctrl_first_reg[POWER_BIT] |=> $stable(data_reg))
    else $error("result changed while powered off");
  a_sample_len: assert property (@(posedge clk) disable iff (!rstn)
    $rose(sample_hold) && ctrl_second_reg[2:0] == 3'h0 && ctrl_first_reg[POWER_BIT]
      |-> sample_hold [*4] ##1 !sample_hold)
    else $error("sampling not four periods");
  a_no_idle_launch: assert property (@(posedge clk) disable iff (!rstn)
    $rose(ctrl_first_reg[BUSY_BIT]) |-> $past(ctrl_first_reg[START_BIT])
      && !ctrl_first_reg[START_BIT])
    else $error("conversion began without full start pulse");
  c_done: cover property (@(posedge clk) disable iff (!rstn) done);
  c_irq: cover property (@(posedge clk) disable iff (!rstn) $rose(irq));
  c_slow: cover property (@(posedge clk) disable iff (!rstn)
    done && ctrl_second_reg[2:0] == 3'h7);
endmodule // adc_conversion_control

// >>> sim/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  import adc_ctrl_pkg::*;
  // bus drive; bready, rready and wstrb are tied
  logic        clk       = 1'b0;
  logic        rstn      = 1'b0;
  logic [7:0]  aw_a      = 8'h00;
  logic        aw_v      = 1'b0;
  logic [31:0] w_d       = 32'h0;
  logic        w_v       = 1'b0;
  logic [7:0]  ar_a      = 8'h00;
  logic        ar_v      = 1'b0;
  logic [11:0] result_in = 12'h000;
  // design outputs
  logic        aw_r, w_r, b_v, ar_r, r_v, power, sh, ce, irq;
  logic [1:0]  b_resp, r_resp;
  logic [31:0] r_d;
  logic [8:0]  pin_mode, pin_kill;
  mux_ctrl_t   mux;
  // bookkeeping
  int          num_errors = 0;
  int          n_compared = 0;
  int          sh_cnt, ce_cnt;
  time         t_b;
  logic [31:0] rv;

  adc_conversion_control u_dut (
    .clk(clk), .rstn(rstn),
    .s_axi_awaddr(aw_a), .s_axi_awvalid(aw_v), .s_axi_awready(aw_r),
    .s_axi_wdata(w_d), .s_axi_wstrb(4'hF), .s_axi_wvalid(w_v), .s_axi_wready(w_r),
    .s_axi_bresp(b_resp), .s_axi_bvalid(b_v), .s_axi_bready(1'b1),
    .s_axi_araddr(ar_a), .s_axi_arvalid(ar_v), .s_axi_arready(ar_r),
    .s_axi_rdata(r_d), .s_axi_rresp(r_resp), .s_axi_rvalid(r_v), .s_axi_rready(1'b1),
    .converter_power_enable(power), .sample_hold(sh), .conv_clock_enable(ce),
    .conv_result(result_in), .mux_ctrl(mux),
    .pin_analog_mode(pin_mode), .pin_pullup_kill(pin_kill), .irq(irq)
  );

  // 50 MHz clock
  always #10 clk = ~clk;

  // count sampling cycles and conversion ticks, sampled mid-cycle
  always @(negedge clk)
  begin
    sh_cnt += int'(sh);
    ce_cnt += int'(ce);
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  // address and data offered together; ready looked at mid-cycle, stable to the edge
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic aw_hit;
    logic w_hit;
    @(posedge clk);
    aw_a <= a;
    aw_v <= 1'b1;
    w_d  <= d;
    w_v  <= 1'b1;
    do
    begin
      @(negedge clk);
      aw_hit = aw_v && aw_r;
      w_hit  = w_v && w_r;
      @(posedge clk);
      if (aw_hit) aw_v <= 1'b0;
      if (w_hit) w_v <= 1'b0;
    end while ((aw_v && !aw_hit) || (w_v && !w_hit));
    do @(negedge clk); while (b_v !== 1'b1);
    t_b = $time;
    chk(32'(b_resp), 32'(er));
    @(posedge clk);
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d, input logic [1:0] er);
    @(posedge clk);
    ar_a <= a;
    ar_v <= 1'b1;
    do @(negedge clk); while (ar_r !== 1'b1);
    @(posedge clk);
    ar_v <= 1'b0;
    do @(negedge clk); while (r_v !== 1'b1);
    d = r_d;
    chk(32'(r_resp), 32'(er));
    @(posedge clk);
  endtask

  // one conversion, software order: divider, then power with start high, then start low
  task automatic convert(input logic [2:0] div, input logic al, input logic [11:0] val);
    int p;
    time n;
    p = 1 << div;
    result_in <= val;
    wr(CTRL_SECOND_OFS, 32'(div), RESP_OKAY);
    wr(CTRL_FIRST_OFS, 32'({3'h5, al, 4'h0}), RESP_OKAY);
    rd(CTRL_FIRST_OFS, rv, RESP_OKAY);
    chk(32'(rv[BUSY_BIT]), 32'h0);
    sh_cnt = 0;
    ce_cnt = 0;
    wr(CTRL_FIRST_OFS, 32'({3'h1, al, 4'h0}), RESP_OKAY);
    if (div >= 3'h3)
    begin
      rd(CTRL_FIRST_OFS, rv, RESP_OKAY);
      chk(32'(rv[BUSY_BIT]), 32'h1);
    end
    while (irq !== 1'b1) @(negedge clk);
    n = ($time - t_b) / 20;
    chk(32'(n >= 16 * p && n <= 16 * p + 1), 32'h1);
    chk(32'(sh_cnt), 32'(4 * p));
    chk(32'(ce_cnt), 32'h10);
    rd(CTRL_FIRST_OFS, rv, RESP_OKAY);
    chk(32'(rv[BUSY_BIT]), 32'h0);
    rd(RESULT_HIGH_OFS, rv, RESP_OKAY);
    chk(rv, al ? 32'(val[11:8]) : 32'(val[11:4]));
    rd(RESULT_LOW_OFS, rv, RESP_OKAY);
    chk(rv, al ? 32'(val[7:0]) : 32'(val[3:0]));
    wr(IRQ_STATUS_OFS, 32'h1, RESP_OKAY);
    chk(32'(irq), 32'h0);
  endtask

  task automatic report_and_stop;
    $display("compared %0d, errors %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // cut a hang short well past the expected run
  initial
  begin
    repeat (40000) @(posedge clk);
    num_errors++;
    report_and_stop();
  end

  // main sequence
  initial
  begin
    logic [3:0] sv;
    logic       ext;
    logic       gnd;
    route_t     er;
    repeat (16) @(posedge clk);
    rstn <= 1'b1;
    rd(CTRL_FIRST_OFS, rv, RESP_OKAY);
    chk(rv, 32'(CTRL_FIRST_RST));
    rd(CTRL_SECOND_OFS, rv, RESP_OKAY);
    chk(rv, 32'(CTRL_SECOND_RST));
    chk(32'(mux.pin_enable), 32'h1);
    wr(CTRL_SECOND_OFS, 32'hFF, RESP_OKAY);
    rd(CTRL_SECOND_OFS, rv, RESP_OKAY);
    chk(rv, 32'hF7);
    wr(PIN_SELECT_OFS, 32'h1A5, RESP_OKAY);
    chk(32'(pin_mode), 32'h1A5);
    chk(32'(pin_kill), 32'h1A5);
    wr(8'h1C, 32'h5, RESP_SLVERR);
    rd(8'h1C, rv, RESP_SLVERR);
    chk(rv, 32'h0);
    // every source code with channel 4 selected
    wr(CTRL_FIRST_OFS, 32'h4, RESP_OKAY);
    for (int s = 0; s < 16; s++)
    begin
      sv = 4'(s);
      wr(CTRL_SECOND_OFS, 32'(sv) << SRC_LSB, RESP_OKAY);
      gnd = (sv[3:2] == 2'h2);
      ext = (sv[3:2] == 2'h3) || (sv[1:0] == 2'h0 && !sv[3]);
      er = gnd ? ROUTE_GROUND : ext ? ROUTE_PIN : sv[2] ? ROUTE_REFERENCE : ROUTE_SUPPLY;
      chk(32'(mux.route), 32'(er));
      chk(32'(mux.pin_enable), ext ? 32'h10 : 32'h0);
      if (!ext && !gnd) chk(32'(mux.scale), 32'(sv[1:0] - 2'h1));
    end
    // every channel code with an external source
    wr(CTRL_SECOND_OFS, 32'hC0, RESP_OKAY);
    for (int c = 0; c < 16; c++)
    begin
      wr(CTRL_FIRST_OFS, 32'(c), RESP_OKAY);
      ext = (c != 2 && c < 9);
      chk(32'(mux.route), 32'(ext ? ROUTE_PIN : ROUTE_FLOAT));
      chk(32'(mux.pin_enable), ext ? 32'h1 << c : 32'h0);
    end
    wr(IRQ_MASK_OFS, 32'h1, RESP_OKAY);
    for (int d = 0; d < 8; d++) convert(3'(d), d[0], 12'hA5C ^ 12'(d << 9));
    chk(32'(power), 32'h1);
    // masked run finished by polling the busy flag
    wr(IRQ_MASK_OFS, 32'h0, RESP_OKAY);
    result_in <= 12'h3C9;
    wr(CTRL_FIRST_OFS, 32'hB0, RESP_OKAY);
    wr(CTRL_FIRST_OFS, 32'h30, RESP_OKAY);
    do rd(CTRL_FIRST_OFS, rv, RESP_OKAY); while (rv[BUSY_BIT] !== 1'b0);
    chk(32'(irq), 32'h0);
    rd(IRQ_STATUS_OFS, rv, RESP_OKAY);
    chk(rv, 32'h1);
    wr(IRQ_MASK_OFS, 32'h1, RESP_OKAY);
    chk(32'(irq), 32'h1);
    wr(IRQ_STATUS_OFS, 32'h1, RESP_OKAY);
    chk(32'(irq), 32'h0);
    // power dropped mid-conversion keeps the old result
    result_in <= 12'hFFF;
    wr(CTRL_SECOND_OFS, 32'h7, RESP_OKAY);
    wr(CTRL_FIRST_OFS, 32'hB0, RESP_OKAY);
    wr(CTRL_FIRST_OFS, 32'h30, RESP_OKAY);
    wr(CTRL_FIRST_OFS, 32'h10, RESP_OKAY);
    chk(32'(power), 32'h0);
    rd(CTRL_FIRST_OFS, rv, RESP_OKAY);
    chk(32'(rv[BUSY_BIT]), 32'h0);
    rd(RESULT_HIGH_OFS, rv, RESP_OKAY);
    chk(rv, 32'h3);
    rd(RESULT_LOW_OFS, rv, RESP_OKAY);
    chk(rv, 32'hC9);
    report_and_stop();
  end
endmodule // tb_top
